// file: src/frid_decoder.v
// The address map and strobed register access are this design's own decisions.
`include "frid_defs.vh"

// Contract
// RULE1 - Add and add-with-carry set five flags.
// RULE2 - OR, AND, XOR update zero, negative.
// RULE3 - Compares skip when true, no flags.
// RULE4 - Decrement skips; plain decrement sets flags.
// RULE5 - Increment skips; plain increment sets flags.
// RULE6 - Carry rotates update carry, zero, negative.
// RULE7 - Plain rotates wrap, update zero, negative.
// RULE8 - Subtract with borrow both ways, flags.
// RULE9 - Multiply one cycle, flags unchanged.
// RULE10 - Bit tests skip on clear or set.
// RULE11 - Port self-modify uses pin levels.
// RULE12 - Timer write-back clears assigned prescaler.
// RULE13 - Skip or jump adds a nop cycle.
// RULE14 - Stray second word executes as nop.
// RULE15 - Literal OR into accumulator, flags.
// RULE16 - Destination bit picks accumulator or register.
// RULE17 - Access bit picks access or selected bank.
// RULE18 - Pointer load writes 12-bit literal.
// RULE19 - Pointer load: high byte, then low.
// RULE20 - Bit field selects bit zero to seven.
// RULE21 - Product split into high, low bytes.
// RULE22 - Flags are carry, digit, zero, overflow, negative.
// RULE23 - No-status instructions keep every flag.
module frid_decoder #(
  parameter DW = 8
) (
  clock,
  rst_n,
  clk_en,
  instr_word,
  instr_valid,
  freg_rdata,
  port_pins,
  prescaler_on_timer_zero_count,
  bank_select_reg,
  freg_addr_r,
  freg_bank_r,
  freg_wdata_r,
  freg_we_r,
  working_accumulator_r,
  status_r,
  product_high_byte_r,
  product_low_byte_r,
  skip_next_r,
  nop_cycle_r,
  prescaler_clr_r,
  ptr_sel_r,
  ptr_hi_we_r,
  ptr_lo_we_r,
  ptr_data_r,
  busy_r
);
  input wire clock;
  input wire rst_n;
  input wire clk_en;
  input wire [15:0] instr_word;
  input wire instr_valid;
  input wire [DW-1:0] freg_rdata;
  input wire [DW-1:0] port_pins;
  input wire prescaler_on_timer_zero_count;
  input wire [3:0] bank_select_reg;
  output reg [7:0] freg_addr_r;
  output reg [3:0] freg_bank_r;
  output reg [DW-1:0] freg_wdata_r;
  output reg freg_we_r;
  output reg [DW-1:0] working_accumulator_r;
  output reg [4:0] status_r;
  output reg [DW-1:0] product_high_byte_r;
  output reg [DW-1:0] product_low_byte_r;
  output reg skip_next_r;
  output reg nop_cycle_r;
  output reg prescaler_clr_r;
  output reg [1:0] ptr_sel_r;
  output reg ptr_hi_we_r;
  output reg ptr_lo_we_r;
  output reg [7:0] ptr_data_r;
  output reg busy_r;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam ST_EXEC = 2'b00;
  localparam ST_LFSR2 = 2'b01;
  localparam ST_SKIPNOP = 2'b10;
  localparam ST_MOVFF2 = 2'b11;

  reg [1:0] state_r;
  reg [1:0] state_nxt;

  wire [5:0] op6 = instr_word[15:10];
  wire [6:0] op7 = instr_word[15:9];
  wire [3:0] op4 = instr_word[15:12];
  wire dest_bit = instr_word[9];
  wire acc_bit = instr_word[8];
  wire [2:0] bit_pos = instr_word[11:9];
  wire [7:0] faddr = instr_word[7:0];

  // Pin levels replace the latch so input pins driven low write back as 0.
  // RULE11 pin operand select
  wire [DW-1:0] opnd = (faddr == `FRID_PORT_ADDR) ? port_pins : freg_rdata;
  wire [DW-1:0] w = working_accumulator_r;
  wire cin = status_r[`FRID_ST_C];

  // ----------------------------------------------------------------
  // Arithmetic datapath
  // ----------------------------------------------------------------
  reg [DW-1:0] res;
  reg [4:0] st_new;
  reg [4:0] st_mask;
  reg writes;
  reg skip;
  reg is_mul;
  reg [DW:0] sum;
  reg [4:0] nib;
  reg [DW-1:0] a_in;
  reg [DW-1:0] b_in;
  reg c_in;

  // Generic adder: a + b + c, borrow forms fed with inverted operand.
  always @*
  begin
    a_in = w;
    b_in = opnd;
    c_in = 1'b0;
    res = opnd;
    st_mask = 5'h00;
    writes = 1'b0;
    skip = 1'b0;
    is_mul = 1'b0;
    case (op6)
      `FRID_OP6_ADD, `FRID_OP6_ADDC:
      begin
        // RULE1 add decode
        c_in = (op6 == `FRID_OP6_ADDC) ? cin : 1'b0;
      end
      `FRID_OP6_SUB_ACC_FROM_REG_BORROW:
      begin
        // RULE8 reg minus acc
        a_in = opnd;
        b_in = ~w;
        c_in = cin;
      end
      `FRID_OP6_SUB_REG_FROM_ACC_BORROW:
      begin
        // RULE8 acc minus reg
        b_in = ~opnd;
        c_in = cin;
      end
      `FRID_OP6_DEC, `FRID_OP6_DECSZ, `FRID_OP6_DECSNZ:
      begin
        a_in = opnd;
        b_in = {DW{1'b1}};
      end
      `FRID_OP6_INC, `FRID_OP6_INCSZ, `FRID_OP6_INCSNZ:
      begin
        a_in = opnd;
        b_in = {DW{1'b0}};
        c_in = 1'b1;
      end
      default:
      begin
        a_in = w;
      end
    endcase
    sum = {1'b0, a_in} + {1'b0, b_in} + {{DW{1'b0}}, c_in};
    nib = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, c_in};
    st_new[`FRID_ST_C] = sum[DW];
    st_new[`FRID_ST_DC] = nib[4];
    st_new[`FRID_ST_OV] = (a_in[DW-1] == b_in[DW-1]) && (sum[DW-1] != a_in[DW-1]);
    case (op6)
      `FRID_OP6_ADD, `FRID_OP6_ADDC, `FRID_OP6_SUB_ACC_FROM_REG_BORROW, `FRID_OP6_SUB_REG_FROM_ACC_BORROW,
      `FRID_OP6_DEC, `FRID_OP6_INC:
      begin
        // RULE22 five ALU flags
        res = sum[DW-1:0];
        st_mask = 5'h1F;
        writes = 1'b1;
      end
      `FRID_OP6_DECSZ, `FRID_OP6_INCSZ:
      begin
        // RULE4 skip on zero
        res = sum[DW-1:0];
        writes = 1'b1;
        skip = (sum[DW-1:0] == {DW{1'b0}});
      end
      `FRID_OP6_DECSNZ, `FRID_OP6_INCSNZ:
      begin
        // RULE5 skip on nonzero
        res = sum[DW-1:0];
        writes = 1'b1;
        skip = (sum[DW-1:0] != {DW{1'b0}});
      end
      `FRID_OP6_IOR, `FRID_OP6_AND, `FRID_OP6_XOR:
      begin
        // RULE2 logic ops
        res = (op6 == `FRID_OP6_IOR) ? (w | opnd) :
              (op6 == `FRID_OP6_AND) ? (w & opnd) : (w ^ opnd);
        st_mask = 5'h14;
        writes = 1'b1;
      end
      `FRID_OP6_RLC, `FRID_OP6_RRC:
      begin
        // RULE6 rotate through carry
        res = (op6 == `FRID_OP6_RLC) ? {opnd[DW-2:0], cin} : {cin, opnd[DW-1:1]};
        st_new[`FRID_ST_C] = (op6 == `FRID_OP6_RLC) ? opnd[DW-1] : opnd[0];
        st_mask = 5'h15;
        writes = 1'b1;
      end
      `FRID_OP6_RLN, `FRID_OP6_RRN:
      begin
        // RULE7 plain rotate wrap
        res = (op6 == `FRID_OP6_RLN) ? {opnd[DW-2:0], opnd[DW-1]} :
              {opnd[0], opnd[DW-1:1]};
        st_mask = 5'h14;
        writes = 1'b1;
      end
      default:
      begin
        res = opnd;
      end
    endcase
    // RULE3 compare skips
    if (op7 == `FRID_OP7_CPLT)
      skip = (opnd < w);
    if (op7 == `FRID_OP7_CPEQ)
      skip = (opnd == w);
    if (op7 == `FRID_OP7_CPGT)
      skip = (opnd > w);
    // RULE9 multiply no flags
    if (op7 == `FRID_OP7_MUL)
      is_mul = 1'b1;
    // RULE10 bit test skip
    // RULE20 bit position
    if (op4 == `FRID_OP4_BTSC)
      skip = ~opnd[bit_pos];
    if (op4 == `FRID_OP4_BTSS)
      skip = opnd[bit_pos];
    st_new[`FRID_ST_Z] = (res == {DW{1'b0}});
    st_new[`FRID_ST_N] = res[DW-1];
  end

  wire [2*DW-1:0] prod = w * opnd;
  wire is_or_literal_into_acc = (instr_word[15:8] == `FRID_OP8_OR_LITERAL_INTO_ACC);
  wire is_pointer_literal_load = (instr_word[15:8] == `FRID_OP8_POINTER_LITERAL_LOAD) &&
                 (instr_word[7:6] == `FRID_POINTER_LITERAL_LOAD_SUB);
  wire is_reg_to_reg_move = (op4 == `FRID_OP4_REG_TO_REG_MOVE);
  wire [DW-1:0] lit_or = w | instr_word[DW-1:0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_EXEC:
      begin
        if (instr_valid)
        begin
          // RULE13 extra nop cycle
          if (is_pointer_literal_load)
            state_nxt = ST_LFSR2;
          else if (is_reg_to_reg_move)
            state_nxt = ST_MOVFF2;
          else if (skip)
            state_nxt = ST_SKIPNOP;
        end
      end
      ST_LFSR2, ST_SKIPNOP, ST_MOVFF2:
      begin
        if (instr_valid)
          state_nxt = ST_EXEC;
      end
      default:
      begin
        state_nxt = ST_EXEC;
      end
    endcase
  end

  // One instruction word consumed per enabled cycle with instr_valid high.
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_r <= ST_EXEC;
      freg_addr_r <= 8'h00;
      freg_bank_r <= `FRID_ACCESS_BANK;
      freg_wdata_r <= {DW{1'b0}};
      freg_we_r <= 1'b0;
      working_accumulator_r <= {DW{1'b0}};
      status_r <= `FRID_ST_RST;
      product_high_byte_r <= {DW{1'b0}};
      product_low_byte_r <= {DW{1'b0}};
      skip_next_r <= 1'b0;
      nop_cycle_r <= 1'b0;
      prescaler_clr_r <= 1'b0;
      ptr_sel_r <= 2'h0;
      ptr_hi_we_r <= 1'b0;
      ptr_lo_we_r <= 1'b0;
      ptr_data_r <= `FRID_BYTE_RST;
      busy_r <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      freg_we_r <= 1'b0;
      skip_next_r <= 1'b0;
      nop_cycle_r <= 1'b0;
      prescaler_clr_r <= 1'b0;
      ptr_hi_we_r <= 1'b0;
      ptr_lo_we_r <= 1'b0;
      busy_r <= (state_nxt != ST_EXEC);
      if (instr_valid && state_r == ST_EXEC)
      begin
        freg_addr_r <= faddr;
        // RULE17 bank select
        freg_bank_r <= acc_bit ? bank_select_reg : `FRID_ACCESS_BANK;
        skip_next_r <= skip;
        // RULE14 stray second word
        nop_cycle_r <= (op4 == `FRID_OP4_SECOND);
        if (is_or_literal_into_acc)
        begin
          // RULE15 literal OR
          working_accumulator_r <= lit_or;
          status_r[`FRID_ST_Z] <= (lit_or == {DW{1'b0}});
          status_r[`FRID_ST_N] <= lit_or[DW-1];
        end
        else if (is_pointer_literal_load)
        begin
          // RULE18 pointer index
          // RULE19 high byte first
          ptr_sel_r <= instr_word[5:4];
          ptr_data_r <= {4'h0, instr_word[3:0]};
          ptr_hi_we_r <= 1'b1;
        end
        else if (is_mul)
        begin
          // RULE21 product pair
          product_high_byte_r <= prod[2*DW-1:DW];
          product_low_byte_r <= prod[DW-1:0];
        end
        else if (writes)
        begin
          // RULE23 masked flag update
          status_r <= (status_r & ~st_mask) | (st_new & st_mask);
          // RULE16 destination select
          if (dest_bit)
          begin
            freg_wdata_r <= res;
            freg_we_r <= 1'b1;
            // RULE12 prescaler clear
            prescaler_clr_r <= (faddr == `FRID_TIMER_ZERO_COUNT_ADDR) && prescaler_on_timer_zero_count;
          end
          else
            working_accumulator_r <= res;
        end
      end
      else if (instr_valid && state_r == ST_LFSR2)
      begin
        // RULE19 low byte second
        ptr_data_r <= instr_word[7:0];
        ptr_lo_we_r <= 1'b1;
      end
      else if (instr_valid)
      begin
        // RULE14 second word nop
        // RULE13 nop second cycle
        nop_cycle_r <= 1'b1;
      end
    end
  end
endmodule // frid_decoder

// file: src/frid_defs.vh
`ifndef FRID_DEFS_VH
`define FRID_DEFS_VH
// ----------------------------------------------------------------
// Opcode patterns: upper-byte fields plus the pointer-load sub-field in bits 7:6
// ----------------------------------------------------------------
`define FRID_OP6_MUL 6'h00
`define FRID_OP6_DEC 6'h01
`define FRID_OP6_IOR 6'h04
`define FRID_OP6_AND 6'h05
`define FRID_OP6_XOR 6'h06
`define FRID_OP6_ADDC 6'h08
`define FRID_OP6_ADD 6'h09
`define FRID_OP6_INC 6'h0A
`define FRID_OP6_DECSZ 6'h0B
`define FRID_OP6_RRC 6'h0C
`define FRID_OP6_RLC 6'h0D
`define FRID_OP6_INCSZ 6'h0F
`define FRID_OP6_RRN 6'h10
`define FRID_OP6_RLN 6'h11
`define FRID_OP6_INCSNZ 6'h12
`define FRID_OP6_DECSNZ 6'h13
`define FRID_OP6_SUB_REG_FROM_ACC_BORROW 6'h15
`define FRID_OP6_SUB_ACC_FROM_REG_BORROW 6'h16
`define FRID_OP7_MUL 7'h01
`define FRID_OP7_CPLT 7'h30
`define FRID_OP7_CPEQ 7'h31
`define FRID_OP7_CPGT 7'h32
`define FRID_OP4_BTSS 4'hA
`define FRID_OP4_BTSC 4'hB
`define FRID_OP4_REG_TO_REG_MOVE 4'hC
`define FRID_OP4_SECOND 4'hF
`define FRID_OP8_OR_LITERAL_INTO_ACC 8'h09
`define FRID_OP8_POINTER_LITERAL_LOAD 8'hEE
`define FRID_POINTER_LITERAL_LOAD_SUB 2'h0
// ----------------------------------------------------------------
// Status flag bit positions, reset values, access bank and fixed addresses
// ----------------------------------------------------------------
`define FRID_ST_C 0
`define FRID_ST_DC 1
`define FRID_ST_Z 2
`define FRID_ST_OV 3
`define FRID_ST_N 4
`define FRID_ST_RST 5'h00
`define FRID_BYTE_RST 8'h00
`define FRID_ACCESS_BANK 4'h0
`define FRID_PORT_ADDR 8'h81
`define FRID_TIMER_ZERO_COUNT_ADDR 8'hD6
`endif

// file: verif/frid_dec_properties.sv
module frid_dec_props (
  input logic clock, rst_n, clk_en, instr_valid, prescaler_on_timer_zero_count, busy_r,
  input logic [15:0] instr_word,
  input logic [7:0] freg_rdata, working_accumulator_r, product_high_byte_r,
  input logic [7:0] product_low_byte_r, ptr_data_r,
  input logic [4:0] status_r,
  input logic freg_we_r, skip_next_r, nop_cycle_r, prescaler_clr_r, ptr_hi_we_r, ptr_lo_we_r
);
  timeunit 1ns;
  timeprecision 1ns;
  // A word counts only when the decoder takes it outside a second-word or nop slot.
  wire tk = clk_en && instr_valid && !busy_r;
  wire bt = freg_rdata[instr_word[11:9]] ^ instr_word[12];
  wire add = tk && instr_word[15:10] == 6'h09;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_hi;
    tk && instr_word[15:6] == 10'h3B8 ##1 ptr_hi_we_r;
  endsequence
  property p_ior;
    tk && instr_word[15:8] == 8'h09 |=> working_accumulator_r ==
      ($past(working_accumulator_r) | $past(instr_word[7:0]));
  endproperty
  a_ior: assert property (p_ior) else $error("literal or result wrong");
  property p_mul;
    tk && instr_word[15:9] == 7'h01 && instr_word[7:0] != 8'h81 |=> $stable(status_r) &&
      {product_high_byte_r, product_low_byte_r} == $past(working_accumulator_r) * $past(freg_rdata);
  endproperty
  a_mul: assert property (p_mul) else $error("product or flags wrong");
  property p_cmp;
    tk && instr_word[15:11] == 5'h0C |=> $stable(status_r);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare touched flags");
  property p_skip;
    skip_next_r && clk_en && instr_valid |=> nop_cycle_r;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped word not a nop");
  property p_dest;
    add |=> freg_we_r == $past(instr_word[9]);
  endproperty
  a_dest: assert property (p_dest) else $error("destination write wrong");
  property p_bit;
    tk && instr_word[15:13] == 3'h5 && instr_word[7:0] != 8'h81 |=> skip_next_r == $past(bt);
  endproperty
  a_bit: assert property (p_bit) else $error("bit test skip wrong");
  property p_pointer_literal_load;
    s_hi ##0 clk_en && instr_valid |=> ptr_lo_we_r && ptr_data_r == $past(instr_word[7:0]);
  endproperty
  a_pointer_literal_load: assert property (p_pointer_literal_load) else $error("pointer low byte wrong");
  property p_tmr;
    add && instr_word[9:0] == 10'h2D6 && prescaler_on_timer_zero_count |=> prescaler_clr_r;
  endproperty
  a_tmr: assert property (p_tmr) else $error("prescaler not cleared");
endmodule // frid_dec_props

bind frid_decoder frid_dec_props chk_u (.*);

// file: verif/frid_decoder_tb.sv
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module frid_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic instr_valid = 1'b0;
  logic prescaler_on_timer_zero_count = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0] port_pins = 8'h00;
  logic [3:0] bank_select_reg = 4'h0;
  logic [7:0] freg_rdata, freg_addr_r, freg_wdata_r, working_accumulator_r, w, fv, r;
  logic [7:0] product_high_byte_r, product_low_byte_r, ptr_data_r;
  logic [4:0] status_r, st;
  logic [3:0] freg_bank_r;
  logic [1:0] ptr_sel_r;
  logic freg_we_r, skip_next_r, nop_cycle_r, prescaler_clr_r, ptr_hi_we_r, ptr_lo_we_r, busy_r;
  logic [15:0] word;
  logic [11:0] k;
  logic [5:0] op;
  logic sk;
  int errors = 0;
  int checks = 0;
  int n;
  logic [5:0] ops [17] = '{6'h09, 6'h08, 6'h04, 6'h05, 6'h06, 6'h0A, 6'h0F, 6'h12, 6'h01,
    6'h0B, 6'h13, 6'h0C, 6'h0D, 6'h10, 6'h11, 6'h15, 6'h16};
  frid_decoder dut_u (.*);
  frid_mem_model mem_u (.clock(clock), .we(freg_we_r), .waddr({freg_bank_r, freg_addr_r}),
    .raddr({instr_word[8] ? bank_select_reg : 4'h0, instr_word[7:0]}),
    .wdata(freg_wdata_r), .rdata(freg_rdata));
  // Free-running core clock.
  initial
  begin
    forever #50 clock = ~clock;
  end
  // Hang guard far beyond the few hundred cycles the run needs.
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    test_done();
  end
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Holds valid high, so consecutive calls give back-to-back words.
  task automatic issue(input logic [15:0] x);
    instr_word <= x;
    instr_valid <= 1'b1;
    st = status_r;
    w = working_accumulator_r;
    #1 fv = freg_rdata;
    @(posedge clock);
    #1;
  endtask
  task automatic idle;
    instr_valid <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  // Operand address clear of the port, whose operand differs, and the timer, whose write clears the prescaler.
  function automatic logic [7:0] fr;
    fr = 8'($urandom);
    if (fr == 8'h81 || fr == 8'hD6)
      fr = 8'h42;
  endfunction
  // Carry set means no borrow on the subtracts.
  function automatic logic [7:0] alu(input logic [5:0] o, input logic [7:0] a, f, input logic c);
    case (o)
      6'h09: alu = a + f;
      6'h08: alu = a + f + c;
      6'h04: alu = a | f;
      6'h05: alu = a & f;
      6'h06: alu = a ^ f;
      6'h0A, 6'h0F, 6'h12: alu = f + 8'h01;
      6'h01, 6'h0B, 6'h13: alu = f - 8'h01;
      6'h0C: alu = {c, f[7:1]};
      6'h0D: alu = {f[6:0], c};
      6'h10: alu = {f[0], f[7:1]};
      6'h11: alu = {f[6:0], f[7]};
      6'h15: alu = a - f - !c;
      default: alu = f - a - !c;
    endcase
  endfunction
  initial
  begin
    n = $urandom(49);
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    repeat (60)
    begin
      op = ops[$urandom % 17];
      bank_select_reg <= 4'($urandom);
      word = {op, 2'($urandom), fr()};
      issue(word);
      r = alu(op, w, fv, st[0]);
      sk = (op == 6'h0B || op == 6'h0F) ? r == 8'h00 : (op == 6'h12 || op == 6'h13) && r != 8'h00;
      if (word[9])
        `CHK(freg_wdata_r, r)
      else
        `CHK(working_accumulator_r, r)
      `CHK(freg_bank_r, word[8] ? bank_select_reg : 4'h0)
      `CHK(skip_next_r, sk)
      `CHK(busy_r, sk)
      `CHK(freg_addr_r, word[7:0])
      if (op inside {6'h0B, 6'h0F, 6'h12, 6'h13})
        `CHK(status_r, st)
      else
        `CHK({status_r[4], status_r[2]}, {r[7], r == 8'h00})
      if (op == 6'h0D)
        `CHK(status_r[0], fv[7])
      issue(16'h0000);
      `CHK(nop_cycle_r, sk)
      idle();
    end
    $display("test alu done");
    repeat (40)
    begin
      k = 12'($urandom);
      sk = 1'b0;
      case (k[10:9])
        2'h0: issue({8'h09, k[7:0]});
        2'h1: issue({7'h01, k[8], fr()});
        2'h2:
        begin
          issue({7'h30 + 7'(k % 3), k[8], fr()});
          sk = (k % 3 == 0) ? fv < w : (k % 3 == 1) ? fv == w : fv > w;
          `CHK({skip_next_r, status_r}, {sk, st})
        end
        default:
        begin
          issue({3'h5, k[8], k[11], k[7:6], k[5], fr()});
          sk = fv[{k[11], k[7:6]}] ^ k[8];
          `CHK(skip_next_r, sk)
        end
      endcase
      issue(16'h0000);
      `CHK(nop_cycle_r, sk)
      issue({10'h3B8, k[1:0], k[11:8]});
      `CHK({ptr_hi_we_r, ptr_sel_r, ptr_data_r}, {1'b1, k[1:0], 4'h0, k[11:8]})
      issue({8'hF0, k[7:0]});
      `CHK({ptr_lo_we_r, ptr_data_r, status_r}, {1'b1, k[7:0], st})
      idle();
    end
    $display("test mixed done");
    port_pins <= 8'($urandom);
    issue(16'h1081);
    `CHK(working_accumulator_r, w | port_pins)
    for (n = 0; n < 2; n++)
    begin
      prescaler_on_timer_zero_count <= n[0];
      issue(16'h26D6);
      `CHK(prescaler_clr_r, n[0])
    end
    issue(16'hC123);
    issue(16'hF456);
    `CHK({nop_cycle_r, freg_we_r}, 2'b10)
    issue(16'hF789);
    `CHK(nop_cycle_r, 1'b1)
    clk_en <= 1'b0;
    issue(16'h09FF);
    `CHK(working_accumulator_r, w)
    clk_en <= 1'b1;
    idle();
    $display("test corners done");
    test_done();
  end
endmodule // frid_decoder_tb

// file: verif/frid_mem_model.sv
module frid_mem_model (
  input logic clock,
  input logic we,
  input logic [11:0] raddr,
  input logic [11:0] waddr,
  input logic [7:0] wdata,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [4096];
  // A varied pattern, so a stale or misrouted operand shows as a wrong result.
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i * 37);
  end
  assign rdata = mem[raddr];
  always @(posedge clock)
  begin
    if (we)
      mem[waddr] <= wdata;
  end
endmodule // frid_mem_model
